// File: src/power_saving_pkg.sv
// Constants, types and field layout for the power-saving mode controller
// What this block does
// - With doze on, CPU runs one instruction cycle in N, N from ratio field
// - Ratio 100 gives 1:32, ratio 001 gives 1:4
// - Peripherals stay clocked at full speed during doze idle cycles
// - Doze keeps oscillators running; only CPU and program memory throttle
// - Program memory still fetches for the next active cycle in doze
// - Entering a service routine copies doze enable into doze-on-exit
// - Doze on, recover off: routine runs dozing, doze enable stays 1
// - Doze and recover on: interrupt restores full speed, doze enable reads 0
// - Return sets doze enable from doze-on-exit, resuming doze or normal run
// - Software may rewrite doze-on-exit inside the service routine
// - Sleep instruction enters Sleep if idle select is 0, Idle if 1
// - Sleep entry clears the watchdog; it counts only if enabled in Sleep
// - Sleep entry clears power-down flag and sets timeout flag
// - Low and high frequency internal and secondary oscillators run in Sleep
// - Sleep keeps RC-clocked ADC conversion; system-clocked one aborts, result invalid
// - Pins hold prior drive state in Sleep unless an async peripheral drives
// - All resets except the watchdog behave normally in Sleep
// - Idle halts CPU and memory, peripherals run; any interrupt ends Idle
// - Every wake-up from Sleep clears the watchdog
package power_saving_pkg;
	localparam int IO_WIDTH = 8;
	localparam int CNT_WIDTH = 8;
	// Register byte addresses
	localparam logic [7:0] ADDR_DOZE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// Control register fields
	localparam int BIT_IDLE_SELECT = 7;
	localparam int BIT_DOZE_ENABLE = 6;
	localparam int BIT_RECOVER = 5;
	localparam int BIT_DOZE_EXIT = 4;
	localparam int RATIO_MSB = 2;
	// Status register fields
	localparam int BIT_TIMEOUT = 0;
	localparam int BIT_POWER_DOWN = 1;
	localparam int MODE_LSB = 2;
	localparam int MODE_MSB = 3;
	// Ratio codes with fixed meanings
	localparam logic [2:0] RATIO_1_4 = 3'h1;
	localparam logic [2:0] RATIO_1_32 = 3'h4;
	typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_SLEEP} mode_type;
	// Last count of a doze period: N = 2^(code+1)
	function automatic logic [CNT_WIDTH-1:0] last_slot(input logic [2:0] code);
		logic [CNT_WIDTH:0] n;
		n = (CNT_WIDTH+1)'(1) << ({1'b0, code} + 4'h1); // Four bits: code 7 must not wrap
		return CNT_WIDTH'(n - (CNT_WIDTH+1)'(1));
	endfunction
endpackage

// File: src/power_mode_if.sv
// Carrier between the controller and its divider and pin-hold helpers
`timescale 1ns/1ps
interface power_mode_if;
	logic       dozeOn;
	logic [2:0] ratio;
	logic       activeSlot;
	logic       holdPins;
	modport ctl (output dozeOn, ratio, holdPins, input activeSlot);
	modport div (input dozeOn, ratio, output activeSlot);
	modport hold (input holdPins);
endinterface

// File: src/doze_divider.sv
// Doze slot counter: one active instruction cycle in every N
`timescale 1ns/1ps
module doze_divider
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Mode carrier
	power_mode_if.div pm
);
	logic [power_saving_pkg::CNT_WIDTH-1:0] slot;

	// Count slots; restart so the first doze cycle is an active one
	always_ff @(posedge clk)
	begin
		if (srst || !pm.dozeOn)
			slot <= '0;
		else if (slot >= power_saving_pkg::last_slot(pm.ratio))
			slot <= '0;
		else
			slot <= slot + 1'b1;
	end

	assign pm.activeSlot = (slot == '0);
endmodule

// File: src/pin_hold.sv
// Holds pin drive state while asleep, except pins an async peripheral owns
`timescale 1ns/1ps
module pin_hold
(
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 srst,
	// Mode carrier
	power_mode_if.hold                                pm,
	// Port logic and async peripheral drive
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] portOut,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] portOe,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOwn,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOut,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOe,
	// Pad drive
	output logic      [power_saving_pkg::IO_WIDTH-1:0] padOut,
	output logic      [power_saving_pkg::IO_WIDTH-1:0] padOe
);
	genvar i;
	generate
		for (i = 0; i < power_saving_pkg::IO_WIDTH; i++)
		begin : g_pin
			// Async owner wins; otherwise freeze while held
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					padOut[i] <= 1'b0;
					padOe[i] <= 1'b0;
				end
				else if (asyncOwn[i])
				begin
					padOut[i] <= asyncOut[i];
					padOe[i] <= asyncOe[i];
				end
				else if (!pm.holdPins)
				begin
					padOut[i] <= portOut[i];
					padOe[i] <= portOe[i];
				end
			end
		end
	endgenerate

	// Every held edge freezes all pins the async side did not own at that edge
	AST_PIN_HOLD: assert property (@(posedge clk) disable iff (srst)
		pm.holdPins |=> (((padOut ^ $past(padOut)) | (padOe ^ $past(padOe)))
			& ~$past(asyncOwn)) == '0)
		else $error("held pin changed while asleep");
endmodule

// File: src/power_saving_mode_control.sv
// Power-saving mode controller: doze throttle, idle and sleep sequencing
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module power_saving_mode_control
(
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 srst,
	// APB slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// CPU core events
	input  wire logic                                 sleepInstr,
	input  wire logic                                 isrEntry,
	input  wire logic                                 isrReturn,
	input  wire logic                                 irqPending,
	// Watchdog
	input  wire logic                                 wdtTimeout,
	input  wire logic                                 wdtSleepEnable,
	output logic                                      wdtClear,
	output logic                                      wdtRun,
	output logic                                      wdtResetReq,
	// ADC
	input  wire logic                                 adcBusy,
	input  wire logic                                 adcDone,
	input  wire logic                                 adcUsesRc,
	output logic                                      adcAbort,
	output logic                                      adcResultValid,
	// Clock gates and oscillator runs
	output logic                                      cpuClkEn,
	output logic                                      progMemEn,
	output logic                                      periphClkEn,
	output logic                                      sysClkRun,
	output logic                                      lowFreqOscRun,
	output logic                                      highFreqOscRun,
	output logic                                      secondaryOscRun,
	// Pins
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] portOut,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] portOe,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOwn,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOut,
	input  wire logic [power_saving_pkg::IO_WIDTH-1:0] asyncOe,
	output logic      [power_saving_pkg::IO_WIDTH-1:0] padOut,
	output logic      [power_saving_pkg::IO_WIDTH-1:0] padOe
);
	power_saving_pkg::mode_type mode;
	logic       idleSelect;
	logic       dozeEnable;
	logic       recoverOnIrq;
	logic       dozeOnExit;
	logic [2:0] ratio;
	logic       powerDownFlag;
	logic       timeoutFlag;
	logic       setupPhase;
	logic       wrEn;
	logic       sleepGo;
	logic       enterSleep;
	logic       enterIdle;
	logic       wakeUp;
	logic       ctrlHit;
	logic       statHit;

	power_mode_if pm ();

	doze_divider u_div
	(
		.clk  (clk),
		.srst (srst),
		.pm   (pm)
	);

	pin_hold u_pins
	(
		.clk      (clk),
		.srst     (srst),
		.pm       (pm),
		.portOut  (portOut),
		.portOe   (portOe),
		.asyncOwn (asyncOwn),
		.asyncOut (asyncOut),
		.asyncOe  (asyncOe),
		.padOut   (padOut),
		.padOe    (padOe)
	);

	// Bus decode; pready is registered so every access gets one access cycle
	assign setupPhase = psel && !penable;
	assign ctrlHit = (paddr == power_saving_pkg::ADDR_DOZE_CTRL);
	assign statHit = (paddr == power_saving_pkg::ADDR_STATUS);
	assign wrEn = psel && penable && pready && pwrite;

	// Sleep instruction acts only in run; a pending interrupt makes it a no-op
	assign sleepGo = sleepInstr && (mode == power_saving_pkg::MODE_RUN) && !irqPending;
	assign enterSleep = sleepGo && !idleSelect;
	assign enterIdle = sleepGo && idleSelect;
	// Interrupt ends Idle or Sleep regardless of the global enable
	assign wakeUp = (mode != power_saving_pkg::MODE_RUN) && (irqPending || wdtTimeout);

	assign pm.dozeOn = dozeEnable;
	assign pm.ratio = ratio;
	assign pm.holdPins = (mode == power_saving_pkg::MODE_SLEEP);

	// Mode sequencer
	always_ff @(posedge clk)
	begin
		if (srst)
			mode <= power_saving_pkg::MODE_RUN;
		else
		begin
			unique case (mode)
				power_saving_pkg::MODE_RUN:
					if (enterSleep)
						mode <= power_saving_pkg::MODE_SLEEP;
					else if (enterIdle)
						mode <= power_saving_pkg::MODE_IDLE;
				power_saving_pkg::MODE_IDLE,
				power_saving_pkg::MODE_SLEEP:
					if (wakeUp)
						mode <= power_saving_pkg::MODE_RUN;
				default:
					mode <= power_saving_pkg::MODE_RUN;
			endcase
		end
	end

	// Control fields; hardware events win over a write in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			idleSelect <= 1'b0;
			recoverOnIrq <= 1'b0;
			ratio <= '0;
		end
		else if (wrEn && ctrlHit)
		begin
			idleSelect <= pwdata[power_saving_pkg::BIT_IDLE_SELECT];
			recoverOnIrq <= pwdata[power_saving_pkg::BIT_RECOVER];
			ratio <= pwdata[power_saving_pkg::RATIO_MSB:0];
		end
	end

	// Doze enable: software, cleared on recover, reloaded on return
	always_ff @(posedge clk)
	begin
		if (srst)
			dozeEnable <= 1'b0;
		else if (isrReturn)
			dozeEnable <= dozeOnExit;
		else if (isrEntry && dozeEnable && recoverOnIrq)
			dozeEnable <= 1'b0;
		else if (isrEntry)
			dozeEnable <= dozeEnable;
		else if (wrEn && ctrlHit)
			dozeEnable <= pwdata[power_saving_pkg::BIT_DOZE_ENABLE];
	end

	// Doze-on-exit: captured on entry, still writable inside the routine
	always_ff @(posedge clk)
	begin
		if (srst)
			dozeOnExit <= 1'b0;
		else if (isrEntry)
			dozeOnExit <= dozeEnable;
		else if (wrEn && ctrlHit)
			dozeOnExit <= pwdata[power_saving_pkg::BIT_DOZE_EXIT];
	end

	// Status flags; sleep entry wins over a software write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			powerDownFlag <= 1'b1;
			timeoutFlag <= 1'b1;
		end
		else if (enterSleep)
		begin
			powerDownFlag <= 1'b0;
			timeoutFlag <= 1'b1;
		end
		else if (wrEn && statHit)
		begin
			powerDownFlag <= pwdata[power_saving_pkg::BIT_POWER_DOWN];
			timeoutFlag <= pwdata[power_saving_pkg::BIT_TIMEOUT];
		end
	end

	// CPU and memory gates; memory follows the CPU slot so prefetch is kept
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cpuClkEn <= 1'b0;
			progMemEn <= 1'b0;
		end
		else
		begin
			cpuClkEn <= (mode == power_saving_pkg::MODE_RUN) && !sleepGo
				&& (!dozeEnable || pm.activeSlot);
			progMemEn <= (mode == power_saving_pkg::MODE_RUN) && !sleepGo
				&& (!dozeEnable || pm.activeSlot);
		end
	end

	// System and peripheral clocks stop only in Sleep, never for doze
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			periphClkEn <= 1'b1;
			sysClkRun <= 1'b1;
		end
		else
		begin
			periphClkEn <= !((mode == power_saving_pkg::MODE_SLEEP && !wakeUp) || enterSleep);
			sysClkRun <= !((mode == power_saving_pkg::MODE_SLEEP && !wakeUp) || enterSleep);
		end
	end

	// Slow and secondary oscillators are never stopped by this block
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			lowFreqOscRun <= 1'b1;
			highFreqOscRun <= 1'b1;
			secondaryOscRun <= 1'b1;
		end
		else
		begin
			lowFreqOscRun <= 1'b1;
			highFreqOscRun <= 1'b1;
			secondaryOscRun <= 1'b1;
		end
	end

	// Watchdog: clear on sleep entry and every wake from Sleep; timeout asleep is a wake
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wdtClear <= 1'b0;
			wdtRun <= 1'b1;
			wdtResetReq <= 1'b0;
		end
		else
		begin
			wdtClear <= enterSleep
				|| (wakeUp && mode == power_saving_pkg::MODE_SLEEP);
			wdtRun <= !((mode == power_saving_pkg::MODE_SLEEP && !wakeUp) || enterSleep)
				|| wdtSleepEnable;
			wdtResetReq <= wdtTimeout && (mode == power_saving_pkg::MODE_RUN);
		end
	end

	// ADC: system-clocked conversion is lost on sleep entry
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			adcAbort <= 1'b0;
			adcResultValid <= 1'b0;
		end
		else
		begin
			adcAbort <= enterSleep && adcBusy && !adcUsesRc;
			if (enterSleep && adcBusy && !adcUsesRc)
				adcResultValid <= 1'b0;
			else if (adcDone)
				adcResultValid <= 1'b1;
		end
	end

	// Bus answer, prepared in the setup cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= setupPhase;
			pslverr <= setupPhase && !ctrlHit && !statHit;
			prdata <= '0;
			if (setupPhase && !pwrite && ctrlHit)
			begin
				prdata[power_saving_pkg::BIT_IDLE_SELECT] <= idleSelect;
				prdata[power_saving_pkg::BIT_DOZE_ENABLE] <= dozeEnable;
				prdata[power_saving_pkg::BIT_RECOVER] <= recoverOnIrq;
				prdata[power_saving_pkg::BIT_DOZE_EXIT] <= dozeOnExit;
				prdata[power_saving_pkg::RATIO_MSB:0] <= ratio;
			end
			else if (setupPhase && !pwrite && statHit)
			begin
				prdata[power_saving_pkg::BIT_TIMEOUT] <= timeoutFlag;
				prdata[power_saving_pkg::BIT_POWER_DOWN] <= powerDownFlag;
				prdata[power_saving_pkg::MODE_MSB:power_saving_pkg::MODE_LSB] <= mode;
			end
		end
	end

	// Checks
	AST_DOZE_QUARTER: assert property (@(posedge clk) disable iff (srst)
		cpuClkEn && dozeEnable && $past(dozeEnable) && ratio == power_saving_pkg::RATIO_1_4
		|=> (!cpuClkEn || !dozeEnable)[*3])
		else $error("doze 1:4 ran CPU in an idle slot");
	AST_ISR_CAPTURE: assert property (@(posedge clk) disable iff (srst)
		isrEntry && !isrReturn |=> dozeOnExit == $past(dozeEnable))
		else $error("doze-on-exit not captured at entry");
	AST_ISR_RECOVER: assert property (@(posedge clk) disable iff (srst)
		isrEntry && !isrReturn && dozeEnable && recoverOnIrq |=> !dozeEnable ##1 cpuClkEn)
		else $error("recover did not restore full speed");
	AST_ISR_STAY: assert property (@(posedge clk) disable iff (srst)
		isrEntry && !isrReturn && dozeEnable && !recoverOnIrq |=> dozeEnable)
		else $error("doze dropped without recover");
	AST_ISR_RETURN: assert property (@(posedge clk) disable iff (srst)
		isrReturn |=> dozeEnable == $past(dozeOnExit))
		else $error("return did not reload doze enable");
	AST_SLEEP_FLAGS: assert property (@(posedge clk) disable iff (srst)
		enterSleep |=> !powerDownFlag && timeoutFlag && wdtClear && !sysClkRun)
		else $error("sleep entry effects missing");
	AST_WAKE_WDT: assert property (@(posedge clk) disable iff (srst)
		mode == power_saving_pkg::MODE_SLEEP && wakeUp |=> wdtClear && sysClkRun)
		else $error("wake did not clear watchdog");
	AST_IDLE_GATES: assert property (@(posedge clk) disable iff (srst)
		enterIdle |=> mode == power_saving_pkg::MODE_IDLE ##1 (!cpuClkEn && periphClkEn))
		else $error("idle gating wrong");
	AST_ADC_ABORT: assert property (@(posedge clk) disable iff (srst)
		enterSleep && adcBusy && !adcUsesRc |=> adcAbort && !adcResultValid)
		else $error("system-clocked conversion not abandoned");
	AST_WDT_NO_RESET: assert property (@(posedge clk) disable iff (srst)
		wdtTimeout && mode != power_saving_pkg::MODE_RUN |=> !wdtResetReq)
		else $error("watchdog reset while asleep");

	COV_DOZE_ISR: cover property (@(posedge clk) disable iff (srst)
		dozeEnable && recoverOnIrq && isrEntry ##[1:20] isrReturn);
	COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (srst)
		enterSleep ##[1:50] (mode == power_saving_pkg::MODE_SLEEP && wakeUp));
	COV_IDLE_WAKE: cover property (@(posedge clk) disable iff (srst)
		enterIdle ##[1:50] (mode == power_saving_pkg::MODE_IDLE && wakeUp));
endmodule

// File: sim/cpu_core_model.sv
// Behavioural CPU core and peripheral clock consumer facing the controller
`timescale 1ns/1ps
module cpu_core_model
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Gates from the controller
	input  wire logic        cpuClkEn,
	input  wire logic        periphClkEn,
	// Bench requests: bit0 sleep, bit1 entry, bit2 return
	input  wire logic [2:0]  evtReq,
	output logic             evtAck,
	// Instruction events
	output logic             sleepInstr,
	output logic             isrEntry,
	output logic             isrReturn,
	// Executed and peripheral cycle counts
	output logic [15:0]      activeCnt,
	output logic [15:0]      periphCnt
);
	// An instruction retires only on an enabled cycle, so events wait for one
	always_ff @(posedge clk)
	begin
		if (srst || evtAck)
		begin
			evtAck <= 1'b0;
			{isrReturn, isrEntry, sleepInstr} <= 3'h0;
		end
		else if (evtReq != 3'h0 && cpuClkEn)
		begin
			evtAck <= 1'b1;
			{isrReturn, isrEntry, sleepInstr} <= evtReq;
		end
	end

	// Cycle counters let the bench measure throttle ratios
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			activeCnt <= 16'h0;
			periphCnt <= 16'h0;
		end
		else
		begin
			activeCnt <= activeCnt + 16'(cpuClkEn);
			periphCnt <= periphCnt + 16'(periphClkEn);
		end
	end
endmodule

// File: sim/power_saving_mode_control_tb.sv
// Self-checking bench for the power-saving mode controller
`timescale 1ns/1ps
module power_saving_mode_control_tb;
	localparam logic [7:0] CTRL = power_saving_pkg::ADDR_DOZE_CTRL;
	localparam logic [7:0] STAT = power_saving_pkg::ADDR_STATUS;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, portOut, portOe, asyncOwn, asyncOut, asyncOe, padOut, padOe;
	logic [31:0] pwdata, prdata;
	logic        sleepInstr, isrEntry, isrReturn, irqPending, evtAck;
	logic        wdtTimeout, wdtSleepEnable, wdtClear, wdtRun, wdtResetReq;
	logic        adcBusy, adcDone, adcUsesRc, adcAbort, adcResultValid;
	logic        cpuClkEn, progMemEn, periphClkEn, sysClkRun;
	logic        lowFreqOscRun, highFreqOscRun, secondaryOscRun;
	logic [2:0]  evtReq;
	logic [15:0] activeCnt, periphCnt;
	int          n_errors, checks;

	power_saving_mode_control i_dut
	(
		.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleepInstr(sleepInstr), .isrEntry(isrEntry), .isrReturn(isrReturn),
		.irqPending(irqPending), .wdtTimeout(wdtTimeout), .wdtSleepEnable(wdtSleepEnable),
		.wdtClear(wdtClear), .wdtRun(wdtRun), .wdtResetReq(wdtResetReq),
		.adcBusy(adcBusy), .adcDone(adcDone), .adcUsesRc(adcUsesRc), .adcAbort(adcAbort),
		.adcResultValid(adcResultValid), .cpuClkEn(cpuClkEn), .progMemEn(progMemEn),
		.periphClkEn(periphClkEn), .sysClkRun(sysClkRun), .lowFreqOscRun(lowFreqOscRun),
		.highFreqOscRun(highFreqOscRun), .secondaryOscRun(secondaryOscRun),
		.portOut(portOut), .portOe(portOe), .asyncOwn(asyncOwn), .asyncOut(asyncOut),
		.asyncOe(asyncOe), .padOut(padOut), .padOe(padOe)
	);

	cpu_core_model i_core
	(
		.clk(clk), .srst(srst), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
		.evtReq(evtReq), .evtAck(evtAck), .sleepInstr(sleepInstr), .isrEntry(isrEntry),
		.isrReturn(isrReturn), .activeCnt(activeCnt), .periphCnt(periphCnt)
	);

	// Free-running 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic give_up();
		n_errors++;
		close_out();
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			give_up();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rd_val(input logic [7:0] a, output logic [31:0] v);
		logic err;
		apb(1'b0, a, 32'h0, v, err);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] v;
		rd_val(a, v);
		check(name, v, exp);
	endtask

	// Core event through the partner; returns in the cycle after it is taken
	task automatic cpu_event(input logic [2:0] k);
		int i;
		@(posedge clk);
		evtReq <= k;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clk);
			if (evtAck === 1'b1)
				break;
		end
		if (i == 200)
			give_up();
		evtReq <= 3'h0;
		@(negedge clk);
	endtask

	task automatic t_reset();
		logic [31:0] v;
		logic        err;
		rd_chk(CTRL, 32'h0, "ctrl reset");
		rd_chk(STAT, 32'h3, "status reset");
		apb(1'b0, 8'h08, 32'h0, v, err);
		check("unmapped error", 32'(err), 32'h1);
		check("unmapped data", v, 32'h0);
		$display("reset test done");
	endtask

	// Counts executed and peripheral cycles over a window
	task automatic doze_run(input logic [2:0] code, input int cycles, input int expAct);
		logic [15:0] a0, p0;
		int          bad;
		wr(CTRL, 32'h40 | {29'h0, code});
		repeat (4) @(negedge clk);
		a0 = activeCnt;
		p0 = periphCnt;
		bad = 0;
		repeat (cycles)
		begin
			@(negedge clk);
			if (progMemEn !== cpuClkEn)
				bad++;
			if ({lowFreqOscRun, highFreqOscRun, secondaryOscRun, sysClkRun} !== 4'hf)
				bad++;
		end
		check("active cycles", 32'(activeCnt - a0), 32'(expAct));
		check("peripheral cycles", 32'(periphCnt - p0), 32'(cycles));
		check("memory and oscillators", 32'(bad), 32'h0);
	endtask

	task automatic t_doze();
		doze_run(power_saving_pkg::RATIO_1_4, 32, 8);
		doze_run(power_saving_pkg::RATIO_1_32, 64, 2);
		$display("doze test done");
	endtask

	task automatic t_isr();
		logic [15:0] a0;
		wr(CTRL, 32'h41);
		cpu_event(3'h2);
		rd_chk(CTRL, 32'h51, "entry dozing");
		wr(CTRL, 32'h41);
		rd_chk(CTRL, 32'h41, "exit rewritten");
		cpu_event(3'h4);
		rd_chk(CTRL, 32'h01, "return normal");
		wr(CTRL, 32'h61);
		cpu_event(3'h2);
		rd_chk(CTRL, 32'h31, "entry recover");
		a0 = activeCnt;
		repeat (8) @(negedge clk);
		check("full speed", 32'(activeCnt - a0), 32'h8);
		cpu_event(3'h4);
		rd_chk(CTRL, 32'h71, "return dozing");
		wr(CTRL, 32'h0);
		$display("interrupt test done");
	endtask

	task automatic t_sleep();
		portOut <= 8'ha5;
		asyncOwn <= 8'h01;
		wdtSleepEnable <= 1'b1;
		adcDone <= 1'b1;
		@(posedge clk);
		adcDone <= 1'b0;
		adcBusy <= 1'b1;
		cpu_event(3'h1);
		check("gates", 32'({cpuClkEn, sysClkRun, periphClkEn}), 32'h0);
		check("watchdog", 32'({wdtClear, wdtRun}), 32'h3);
		check("adc abort", 32'(adcAbort), 32'h1);
		check("osc", 32'({lowFreqOscRun, highFreqOscRun, secondaryOscRun}), 32'h7);
		@(posedge clk);
		portOut <= 8'h5a;
		repeat (3) @(negedge clk);
		check("pad hold", 32'({padOe, padOut}), 32'hffa4);
		check("adc valid", 32'(adcResultValid), 32'h0);
		rd_chk(STAT, 32'h9, "sleep status");
		wdtTimeout <= 1'b1;
		@(posedge clk);
		wdtTimeout <= 1'b0;
		asyncOwn <= 8'h00;
		@(negedge clk);
		check("wake", 32'({wdtClear, sysClkRun, wdtResetReq}), 32'h6);
		repeat (3) @(negedge clk);
		check("pad release", 32'(padOut), 32'h5a);
		@(posedge clk);
		adcBusy <= 1'b0;
		$display("sleep test done");
	endtask

	task automatic t_idle();
		logic [31:0] v;
		wr(CTRL, 32'h80);
		cpu_event(3'h1);
		repeat (4) @(negedge clk);
		check("idle gates", 32'({cpuClkEn, progMemEn, periphClkEn, sysClkRun}), 32'h3);
		rd_val(STAT, v);
		check("idle mode", 32'(v[3:2]), 32'h1);
		irqPending <= 1'b1;
		repeat (3) @(posedge clk);
		irqPending <= 1'b0;
		rd_val(STAT, v);
		check("idle woken", 32'(v[3:2]), 32'h0);
		rd_chk(CTRL, 32'h80, "idle select kept");
		// Sleep with an RC-clocked conversion in flight, then a watchdog timeout in run
		wr(CTRL, 32'h0);
		adcDone <= 1'b1;
		adcUsesRc <= 1'b1;
		adcBusy <= 1'b1;
		@(posedge clk);
		adcDone <= 1'b0;
		cpu_event(3'h1);
		check("rc adc kept", 32'({adcAbort, adcResultValid}), 32'h1);
		@(posedge clk);
		irqPending <= 1'b1;
		adcBusy <= 1'b0;
		@(posedge clk);
		irqPending <= 1'b0;
		wdtTimeout <= 1'b1;
		@(posedge clk);
		wdtTimeout <= 1'b0;
		@(negedge clk);
		check("run watchdog reset", 32'(wdtResetReq), 32'h1);
		$display("idle test done");
	endtask

	// Main sequence
	initial
	begin
		n_errors = 0;
		checks = 0;
		{psel, penable, pwrite, paddr, pwdata, evtReq} = '0;
		{irqPending, wdtTimeout, wdtSleepEnable, adcBusy, adcDone, adcUsesRc} = '0;
		{portOut, asyncOwn, asyncOut} = '0;
		portOe = 8'hff;
		asyncOe = 8'h01;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_doze();
		t_isr();
		t_sleep();
		t_idle();
		close_out();
	end
endmodule
